// ==== bench/slpg_checker.sv ====
// Port-level assertions for the status LED pattern generator
module slpg_checker
  import slpg_pkg::*;
#(
  parameter int unsigned TICKS = TICK_CYCLES
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        port_in_open,
  input wire logic        port_out_open,
  input wire logic        port_out_100m,
  input wire logic        net_red,
  input wire logic        dev_red,
  input wire logic        port_in_led,
  input wire logic        port_out_led
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_READY_WAIT: assert property (
    psel && penable && !pready |=> pready)
    else $error("no answer after one wait cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held high");
  AST_ERR_MAP: assert property (
    pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > LED_STATUS_OFS))
    else $error("pslverr wrong for address");
  AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  AST_RESET_DARK: assert property (
    $rose(presetn) |-> !net_red && !dev_red)
    else $error("led lit at reset release");
  AST_PORT_CLOSED: assert property (
    !port_in_open |=> !port_in_led)
    else $error("port in led lit while closed");
  AST_PORT_SPEED: assert property (
    !port_out_100m |=> !port_out_led)
    else $error("port out led lit on slow link");
  AST_PORT_RISE: assert property (
    $rose(port_out_led) |-> $past(port_out_open && port_out_100m))
    else $error("port out led rose without open link");
endmodule : slpg_checker

bind slpg_top slpg_checker #(.TICKS(TICKS)) u_checker (.*);

// ==== bench/slpg_led_eye.sv ====
// Operator view of one LED: lit pulses and longest whole runs
module slpg_led_eye
(
  input  wire logic pclk,
  input  wire logic clr,
  input  wire logic led,
  output int        rises,
  output int        max_lit,
  output int        max_dark
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b0;
  logic seen = 1'b0;
  int   run  = 0;
  // Only runs closed by two edges count, so a cut window cannot mislead
  always @(posedge pclk)
  begin
    prev <= led;
    run <= (led !== prev || clr) ? 1 : run + 1;
    if (clr)
    begin
      rises <= 0;
      max_lit <= 0;
      max_dark <= 0;
      seen <= 1'b0;
    end
    else if (led !== prev)
    begin
      rises <= rises + int'(led);
      seen <= 1'b1;
      if (seen && prev && run > max_lit)
        max_lit <= run;
      if (seen && !prev && run > max_dark)
        max_dark <= run;
    end
  end
endmodule : slpg_led_eye

// ==== bench/status_led_pattern_generator_test.sv ====
// Register-driven pattern checks for the status LED pattern generator
module status_led_pattern_generator_test
  import slpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Short tick keeps every pattern within a few hundred cycles
  localparam int TK = 4;
  localparam int BL = 4 * TK;
  localparam int PS = 20 * TK;
  localparam int SL = 10 * TK;
  localparam logic [7:0] NC = NET_CTRL_OFS;
  localparam logic [7:0] DC = DEV_CTRL_OFS;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        clr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic [5:0]  pin = 6'h00;
  logic [5:0]  led;
  int          rises [6];
  int          mlit [6];
  int          mdark [6];
  int          err_total = 0;
  int          samples_checked = 0;

  always #25 pclk = ~pclk;

  slpg_top #(.TICKS(TK)) DUT
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_in_open(pin[0]),
    .port_in_activity(pin[1]), .port_in_100m(pin[2]),
    .port_out_open(pin[3]), .port_out_activity(pin[4]),
    .port_out_100m(pin[5]), .net_green(led[0]), .net_red(led[1]),
    .dev_green(led[2]), .dev_red(led[3]), .port_in_led(led[4]),
    .port_out_led(led[5])
  );

  for (genvar i = 0; i < 6; i++)
  begin : g_eye
    slpg_led_eye u_eye
    (
      .pclk(pclk), .clr(clr), .led(led[i]), .rises(rises[i]),
      .max_lit(mlit[i]), .max_dark(mdark[i])
    );
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    if (n >= 20)
    begin
      check("pready", 1'b0, 1'b1);
      report_and_stop();
    end
    check("pslverr", pslverr, a > LED_STATUS_OFS);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic get(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check("prdata", rd, x);
  endtask : get

  // Patterns run free, so only a settled window of whole periods is judged
  task automatic run(input logic [7:0] a, input logic [31:0] v,
                     input int i, input int r, input int l,
                     input int d, input int lv);
    apb(1'b1, a, v);
    repeat (150) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    repeat (i / 2 == 1 ? 400 : 384) @(posedge pclk);
    #1;
    check("pulses", rises[i], r);
    check("longest lit", mlit[i], l);
    check("longest dark", mdark[i], d);
    if (r == 0)
      check("steady level", led[i], lv);
    @(posedge pclk);
  endtask : run

  initial
  begin
    repeat (5) @(posedge pclk);
    check("leds in reset", led, 6'h00);
    repeat (15) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    get(NC, NET_CTRL_RST);
    get(DC, DEV_CTRL_RST);
    get(LED_CTRL_OFS, LED_CTRL_RST);
    get(8'h10, 32'h0);
    apb(1'b1, LED_STATUS_OFS, 32'hffff_ffff);
    apb(1'b1, NC, 32'hffff_ffff);
    get(NC, 32'h0000_0707);
    run(NC, 32'h0, 0, 0, 0, 0, 0);
    run(NC, 32'h1, 0, 12, BL, BL, 0);
    run(NC, 32'h2, 0, 4, BL, PS, 0);
    run(NC, 32'h4, 0, 48, TK, TK, 0);
    run(NC, 32'h3, 0, 0, 0, 0, 1);
    run(NC, 32'h103, 1, 6, BL, PS, 0);
    run(NC, 32'h203, 1, 4, BL, PS, 0);
    run(NC, 32'h403, 1, 12, BL, BL, 0);
    run(NC, 32'h703, 1, 6, BL, PS, 0);
    run(NC, 32'h603, 1, 4, BL, PS, 0);
    run(NC, 32'h003, 1, 0, 0, 0, 0);
    for (int s = 0; s < 3; s++)
    begin
      run(DC, s, 2, 5, SL, SL, 0);
      check("dev red", led[3], 1'b0);
    end
    run(DC, 32'h3, 2, 0, 0, 0, 1);
    run(DC, 32'h4, 3, 0, 0, 0, 0);
    check("dev green", led[2], 1'b1);
    run(DC, 32'h6, 2, 0, 0, 0, 0);
    check("dev red", led[3], 1'b1);
    // Net OP steady on, device fault red on, ports dark
    get(LED_STATUS_OFS, 32'h0000_0009);
    run(DC, 32'h5, 2, 0, 0, 0, 1);
    check("dev red", led[3], 1'b1);
    run(DC, 32'h103, 2, 5, 2 * TK, 18 * TK, 0);
    check("dev red", led[3], 1'b1);
    run(DC, 32'h206, 2, 5, 2 * TK, 18 * TK, 0);
    pin <= 6'b100100;
    run(LED_CTRL_OFS, 32'h1, 4, 0, 0, 0, 0);
    pin <= 6'b101101;
    run(LED_CTRL_OFS, 32'h1, 4, 0, 0, 0, 1);
    pin <= 6'b111111;
    run(LED_CTRL_OFS, 32'h1, 4, 48, TK, TK, 0);
    run(LED_CTRL_OFS, 32'h1, 5, 48, TK, TK, 0);
    pin <= 6'b011011;
    run(LED_CTRL_OFS, 32'h1, 5, 0, 0, 0, 0);
    check("port in led", led[4], 1'b0);
    // Clearing the enable must darken a port that would otherwise flicker
    pin <= 6'b111111;
    run(LED_CTRL_OFS, 32'h0, 5, 0, 0, 0, 0);
    check("leds disabled", led, 6'h00);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("leds in reset", led, 6'h00);
    report_and_stop();
  end
endmodule : status_led_pattern_generator_test

// ==== logic/slpg_pkg.sv ====
// Shared constants for the status LED pattern generator
package slpg_pkg;

  // Clock and pattern time base
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_TIME_NS  = 50000000;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W    = 20;

  // Pattern times in milliseconds, each a multiple of the 50 ms tick
  localparam int unsigned TICK_MS        = TICK_TIME_NS / 1000000;
  localparam int unsigned FLICKER_MS     = 100;
  localparam int unsigned BLINK_MS       = 400;
  localparam int unsigned SLOW_MS        = 1000;
  localparam int unsigned NET_FLASH_MS   = 200;
  localparam int unsigned NET_PAUSE_MS   = 1000;
  localparam int unsigned DEV_DARK_MS    = 900;
  localparam int unsigned DEV_LIT_MS     = 100;

  localparam int unsigned FLICKER_TICKS   = FLICKER_MS / TICK_MS;
  localparam int unsigned BLINK_TICKS     = BLINK_MS / TICK_MS;
  localparam int unsigned SLOW_TICKS      = SLOW_MS / TICK_MS;
  localparam int unsigned NET_FLASH_TICKS = NET_FLASH_MS / TICK_MS;
  localparam int unsigned NET_PAUSE_TICKS = NET_PAUSE_MS / TICK_MS;
  localparam int unsigned DEV_DARK_TICKS  = DEV_DARK_MS / TICK_MS;
  localparam int unsigned DEV_LIT_TICKS   = DEV_LIT_MS / TICK_MS;

  // Register byte offsets
  localparam logic [7:0] NET_CTRL_OFS   = 8'h00;
  localparam logic [7:0] DEV_CTRL_OFS   = 8'h04;
  localparam logic [7:0] LED_CTRL_OFS   = 8'h08;
  localparam logic [7:0] LED_STATUS_OFS = 8'h0c;

  // Field positions
  localparam int unsigned STATE_LSB      = 0;
  localparam int unsigned STATE_W        = 3;
  localparam int unsigned NET_WDOG_BIT   = 8;
  localparam int unsigned NET_INTERR_BIT = 9;
  localparam int unsigned NET_CFGERR_BIT = 10;
  localparam int unsigned DEV_FWBAD_BIT  = 8;
  localparam int unsigned DEV_FWDL_BIT   = 9;
  localparam int unsigned LED_EN_BIT     = 0;

  // Reset values
  localparam logic [31:0] NET_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DEV_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] LED_CTRL_RST = 32'h0000_0001;

  typedef enum logic [2:0] {
    COMM_INIT    = 3'b000,
    COMM_PREOP   = 3'b001,
    COMM_SAFEOP  = 3'b010,
    COMM_OP      = 3'b011,
    COMM_BOOT    = 3'b100
  } slpg_comm_type;

  typedef enum logic [2:0] {
    DRV_SW_ON_DIS   = 3'b000,
    DRV_READY       = 3'b001,
    DRV_SWITCHED_ON = 3'b010,
    DRV_OP_ENABLED  = 3'b011,
    DRV_QUICK_STOP  = 3'b100,
    DRV_FAULT_REACT = 3'b101,
    DRV_FAULT       = 3'b110
  } slpg_drive_type;

endpackage : slpg_pkg

// ==== logic/slpg_timebase.sv ====
// Free-running divider giving one-cycle 50 ms tick pulses
module slpg_timebase
  import slpg_pkg::*;
#(
  parameter int unsigned TICKS = TICK_CYCLES
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);

  logic [TICK_CNT_W-1:0] count;
  logic [TICK_CNT_W-1:0] next_count;
  logic                  next_tick;

  always_comb
  begin
    next_tick  = 1'b0;
    next_count = count + 1'b1;
    if (count == TICK_CNT_W'(TICKS - 1))
    begin
      next_count = '0;
      next_tick  = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule : slpg_timebase

// ==== logic/slpg_top.sv ====
// Status LED pattern generator with APB register access
//
// Behaviour
// - Net green: INIT off, PREOP blink, SAFEOP single flash, OP on, BOOT flicker.
// - Net red stays off with no error condition present.
// - Net red double-flashes on application watchdog timeout.
// - Net red single-flashes after autonomous state change from internal error.
// - Net red blinks on general configuration error.
// - Net blink toggles continuously at about 2.5 Hz.
// - Flicker, for net green and port LEDs, toggles at about 10 Hz.
// - Net flash lit 0.2 s; flash group followed by 1 s dark pause.
// - Power stage disabled states: device green slow blink, red off.
// - Operation enabled or quick stop: device green on, red off.
// - Fault state: device green off, red on.
// - Fault reaction active: device green and red both on.
// - No valid firmware or download: red on, green flashing.
// - Device flash repeats 0.9 s dark then 0.1 s lit.
// - Device slow blink toggles at about 1 Hz.
// - Each port LED: closed off, open on, open with traffic flickers.
// - Port link indication applies to 100 Mbit/s links.
//
// Chosen here: the APB slave port and the register addresses.
module slpg_top
  import slpg_pkg::*;
#(
  parameter int unsigned TICKS = TICK_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port_in_open,
  input  wire logic        port_in_activity,
  input  wire logic        port_in_100m,
  input  wire logic        port_out_open,
  input  wire logic        port_out_activity,
  input  wire logic        port_out_100m,
  output logic             net_green,
  output logic             net_red,
  output logic             dev_green,
  output logic             dev_red,
  output logic             port_in_led,
  output logic             port_out_led
);

  // Register index 0..3 for a mapped word, 4 for an unmapped address
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    unique case (addr)
      NET_CTRL_OFS:   reg_index = 3'd0;
      DEV_CTRL_OFS:   reg_index = 3'd1;
      LED_CTRL_OFS:   reg_index = 3'd2;
      LED_STATUS_OFS: reg_index = 3'd3;
      default:        reg_index = 3'd4;
    endcase
  endfunction : reg_index

  logic tick;
  logic w_flicker;
  logic w_blink;
  logic w_slow;
  logic w_single;
  logic w_double;
  logic w_devflash;

  slpg_timebase #(.TICKS(TICKS)) u_timebase (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  slpg_wave #(
    .PERIOD (FLICKER_TICKS),
    .A_END  (FLICKER_TICKS / 2)
  ) u_flicker (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .lit     (w_flicker)
  );

  slpg_wave #(
    .PERIOD (BLINK_TICKS),
    .A_END  (BLINK_TICKS / 2)
  ) u_blink (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .lit     (w_blink)
  );

  slpg_wave #(
    .PERIOD (SLOW_TICKS),
    .A_END  (SLOW_TICKS / 2)
  ) u_slow (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .lit     (w_slow)
  );

  slpg_wave #(
    .PERIOD (NET_FLASH_TICKS + NET_PAUSE_TICKS),
    .A_END  (NET_FLASH_TICKS)
  ) u_single (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .lit     (w_single)
  );

  // Double flash: lit, dark gap of one flash length, lit, then the pause
  slpg_wave #(
    .PERIOD  (3 * NET_FLASH_TICKS + NET_PAUSE_TICKS),
    .A_END   (NET_FLASH_TICKS),
    .B_START (2 * NET_FLASH_TICKS),
    .B_END   (3 * NET_FLASH_TICKS)
  ) u_double (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .lit     (w_double)
  );

  slpg_wave #(
    .PERIOD  (DEV_DARK_TICKS + DEV_LIT_TICKS),
    .A_END   (0),
    .B_START (DEV_DARK_TICKS),
    .B_END   (DEV_DARK_TICKS + DEV_LIT_TICKS)
  ) u_devflash (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick),
    .lit     (w_devflash)
  );

  // Register file and APB slave
  logic [31:0] net_ctrl;
  logic [31:0] dev_ctrl;
  logic [31:0] led_ctrl;
  logic [31:0] next_net_ctrl;
  logic [31:0] next_dev_ctrl;
  logic [31:0] next_led_ctrl;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] led_status;
  logic        access;
  logic [2:0]  reg_sel;

  assign led_status = {26'h0, port_out_led, port_in_led,
                       dev_red, dev_green, net_red, net_green};
  assign reg_sel    = reg_index(paddr);
  // Answer on the second access cycle; pready low on the first
  assign access     = psel && penable && !pready;

  always_comb
  begin
    next_net_ctrl = net_ctrl;
    next_dev_ctrl = dev_ctrl;
    next_led_ctrl = led_ctrl;
    next_prdata   = 32'h0000_0000;
    next_pready   = access;
    next_pslverr  = 1'b0;
    if (access)
    begin
      next_pslverr = (reg_sel == 3'd4);
      if (pwrite)
      begin
        if (reg_sel == 3'd0)
          next_net_ctrl = pwdata & 32'h0000_0707;
        if (reg_sel == 3'd1)
          next_dev_ctrl = pwdata & 32'h0000_0307;
        if (reg_sel == 3'd2)
          next_led_ctrl = pwdata & 32'h0000_0001;
      end
      else
      begin
        unique case (reg_sel)
          3'd0:    next_prdata = net_ctrl;
          3'd1:    next_prdata = dev_ctrl;
          3'd2:    next_prdata = led_ctrl;
          3'd3:    next_prdata = led_status;
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      net_ctrl <= NET_CTRL_RST;
      dev_ctrl <= DEV_CTRL_RST;
      led_ctrl <= LED_CTRL_RST;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end
    else
    begin
      net_ctrl <= next_net_ctrl;
      dev_ctrl <= next_dev_ctrl;
      led_ctrl <= next_led_ctrl;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
    end
  end

  // LED decode
  logic [2:0] comm_state;
  logic [2:0] drive_state;
  logic       enabled;
  logic       next_net_green;
  logic       next_net_red;
  logic       next_dev_green;
  logic       next_dev_red;
  logic       next_port_in;
  logic       next_port_out;

  assign comm_state  = net_ctrl[STATE_LSB +: STATE_W];
  assign drive_state = dev_ctrl[STATE_LSB +: STATE_W];
  assign enabled     = led_ctrl[LED_EN_BIT];

  always_comb
  begin
    unique case (comm_state)
      COMM_INIT:   next_net_green = 1'b0;
      COMM_PREOP:  next_net_green = w_blink;
      COMM_SAFEOP: next_net_green = w_single;
      COMM_OP:     next_net_green = 1'b1;
      COMM_BOOT:   next_net_green = w_flicker;
      default:     next_net_green = 1'b0;
    endcase

    if (net_ctrl[NET_WDOG_BIT])
      next_net_red = w_double;
    else if (net_ctrl[NET_INTERR_BIT])
      next_net_red = w_single;
    else if (net_ctrl[NET_CFGERR_BIT])
      next_net_red = w_blink;
    else
      next_net_red = 1'b0;

    // Firmware trouble overrides whatever the drive state claims
    if (dev_ctrl[DEV_FWBAD_BIT] || dev_ctrl[DEV_FWDL_BIT])
    begin
      next_dev_green = w_devflash;
      next_dev_red   = 1'b1;
    end
    else
    begin
      unique case (drive_state)
        DRV_SW_ON_DIS, DRV_READY, DRV_SWITCHED_ON:
        begin
          next_dev_green = w_slow;
          next_dev_red   = 1'b0;
        end
        DRV_OP_ENABLED, DRV_QUICK_STOP:
        begin
          next_dev_green = 1'b1;
          next_dev_red   = 1'b0;
        end
        DRV_FAULT_REACT:
        begin
          next_dev_green = 1'b1;
          next_dev_red   = 1'b1;
        end
        DRV_FAULT:
        begin
          next_dev_green = 1'b0;
          next_dev_red   = 1'b1;
        end
        default:
        begin
          next_dev_green = 1'b0;
          next_dev_red   = 1'b0;
        end
      endcase
    end

    // Only a 100 Mbit/s link is indicated; others leave the LED dark
    next_port_in  = port_in_100m && port_in_open &&
                    (port_in_activity ? w_flicker : 1'b1);
    next_port_out = port_out_100m && port_out_open &&
                    (port_out_activity ? w_flicker : 1'b1);

    if (!enabled)
    begin
      next_net_green = 1'b0;
      next_net_red   = 1'b0;
      next_dev_green = 1'b0;
      next_dev_red   = 1'b0;
      next_port_in   = 1'b0;
      next_port_out  = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      net_green    <= 1'b0;
      net_red      <= 1'b0;
      dev_green    <= 1'b0;
      dev_red      <= 1'b0;
      port_in_led  <= 1'b0;
      port_out_led <= 1'b0;
    end
    else
    begin
      net_green    <= next_net_green;
      net_red      <= next_net_red;
      dev_green    <= next_dev_green;
      dev_red      <= next_dev_red;
      port_in_led  <= next_port_in;
      port_out_led <= next_port_out;
    end
  end

endmodule : slpg_top

// ==== logic/slpg_wave.sv ====
// Periodic lit/dark wave stepped by ticks, with up to two lit windows
module slpg_wave
  import slpg_pkg::*;
#(
  parameter int unsigned PERIOD  = 2,
  parameter int unsigned A_END   = 1,
  parameter int unsigned B_START = 0,
  parameter int unsigned B_END   = 0
)
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tick,
  output logic      lit
);

  logic [5:0] phase;
  logic [5:0] next_phase;
  logic       next_lit;

  always_comb
  begin
    next_phase = phase;
    if (tick)
      next_phase = (phase == 6'(PERIOD - 1)) ? 6'h00 : phase + 6'h01;
    next_lit = (next_phase < 6'(A_END)) ||
               ((next_phase >= 6'(B_START)) && (next_phase < 6'(B_END)));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 6'h00;
      lit   <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      lit   <= next_lit;
    end
  end

endmodule : slpg_wave
